// File: rtl/cpm_pkg.sv
// constants, register map and field layout of the clock ppm monitor
// assumes a 100 MHz system clock and a software master on AXI4-Lite
// Notes on behaviour
// - reference counter runs a 14-bit programmable number of 25 MHz cycles
// - monitor counter on watched 125 MHz clock, wraps at programmed expected count
// - upper limit: largest count after wrap accepted, default for 1000 ppm
// - lower limit: smallest count without wrap accepted, default for 1000 ppm
// - each rollback captures monitor counts into read-only status registers
// - reference count register bits 15-14 read as zero
// - ppm loss flags are sticky, cleared by writing one or reset
// - frequency loss flags are sticky, cleared by writing one or reset
package cpm_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned REG_W = 16;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [9:0] IDX_REF_WINDOW = 10'h1d9;
  localparam logic [9:0] IDX_EXPECTED = 10'h1da;
  localparam logic [9:0] IDX_PLUS_LIM = 10'h1db;
  localparam logic [9:0] IDX_MINUS_LIM = 10'h1dc;
  localparam logic [9:0] IDX_SYS_CAPT = 10'h1dd;
  localparam logic [9:0] IDX_PLL_CAPT = 10'h1de;
  localparam logic [9:0] IDX_FAULT_STAT = 10'h1f0;
  localparam logic [9:0] IDX_FAULT_MASK = 10'h1f1;
  // reset values
  localparam logic [13:0] RST_REF_WINDOW = 14'h30d3;
  localparam logic [15:0] RST_EXPECTED = 16'hf423;
  localparam logic [15:0] RST_PLUS_LIM = 16'h0044;
  localparam logic [15:0] RST_MINUS_LIM = 16'hf3df;
  localparam logic [15:0] RST_CAPT = 16'hf423;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam int unsigned REF_W = 14;
  // fault status bit positions
  localparam int unsigned BIT_SYS_FREQ = 10;
  localparam int unsigned BIT_SYS_PPM = 9;
  localparam int unsigned BIT_PLL_FREQ = 6;
  localparam int unsigned BIT_PLL_PPM = 5;
  localparam logic [15:0] STAT_IMPL = 16'h0660;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // limits that steer the comparison, carried together
  typedef struct packed {
    logic [REF_W-1:0] ref_window;
    logic [15:0] expected;
    logic [15:0] plus_lim;
    logic [15:0] minus_lim;
  } cpm_cfg_t;
endpackage

// File: rtl/cpm_monitor.sv
// clock ppm monitor with AXI4-Lite register slave and one interrupt
// assumes clock ticks and loss events arrive as one-cycle pulses synchronous to sys_clk
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module cpm_monitor
  import cpm_pkg::*;
(
  input wire logic sys_clk, // 100 MHz system clock
  input wire logic arst_n, // async reset, active low
  input wire logic ref_tick, // one 25 MHz reference cycle
  input wire logic [1:0] mon_tick, // one watched cycle: [0] system, [1] pll
  input wire logic [1:0] freq_loss_evt, // frequency lock lost: [0] system, [1] pll
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic irq_q // level interrupt, high while unmasked flag set
);
  cpm_cfg_t cfg_q;
  logic [REF_W-1:0] ref_cnt_q;
  logic [15:0] mon_cnt_q [2];
  logic [15:0] capt_q [2];
  logic [15:0] stat_q;
  logic [15:0] mask_q;
  logic [15:0] stat_clr;
  logic [15:0] stat_set;
  logic rollback;
  logic [1:0] above_plus;
  logic [1:0] below_minus;
  logic [1:0] out_of_win;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [9:0] widx;
  logic [9:0] ridx;
  logic whit;
  logic [15:0] rval;
  logic rhit;

  // reference window countdown
  // counts down to zero then reloads, so a window spans field plus one cycles
  // a new field value takes effect at the next rollback, never mid-window
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_cnt_q <= RST_REF_WINDOW;
    end else if (ref_tick) begin
      if (ref_cnt_q == '0) begin
        ref_cnt_q <= cfg_q.ref_window;
      end else begin
        ref_cnt_q <= ref_cnt_q - 14'h0001;
      end
    end
  end

  // rollback is the tick that finds the counter at zero
  assign rollback = ref_tick && (ref_cnt_q == '0);

  // monitor counters, wrap at expected count
  // restart on rollback so each window starts from zero; a tick in that
  // same cycle counts as the first of the new window, not lost
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_cnt_q[0] <= '0;
      mon_cnt_q[1] <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (rollback) begin
          mon_cnt_q[c] <= {15'h0000, mon_tick[c]};
        end else if (mon_tick[c]) begin
          if (mon_cnt_q[c] == cfg_q.expected) begin
            mon_cnt_q[c] <= '0;
          end else begin
            mon_cnt_q[c] <= mon_cnt_q[c] + 16'h0001;
          end
        end
      end
    end
  end

  // capture on rollback
  // the captured value is the count as it stood before the rollback tick
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      capt_q[0] <= RST_CAPT;
      capt_q[1] <= RST_CAPT;
    end else if (rollback) begin
      capt_q[0] <= mon_cnt_q[0];
      capt_q[1] <= mon_cnt_q[1];
    end
  end

  // window check at rollback
  // limits compared as programmed; plus must stay below minus or every count passes
  always_comb begin
    above_plus = 2'b00;
    below_minus = 2'b00;
    out_of_win = 2'b00;
    for (int c = 0; c < 2; c++) begin
      // wrapped count above plus limit fails
      above_plus[c] = mon_cnt_q[c] > cfg_q.plus_lim;
      // unwrapped count below minus limit fails
      below_minus[c] = mon_cnt_q[c] < cfg_q.minus_lim;
      out_of_win[c] = rollback && above_plus[c] && below_minus[c];
    end
  end

  // handshakes on the three request channels
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // write path: address and data latched in either order
  // each half waits for the other, then both retire together
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // ready low while a half is held or a response waits
  // registered readies keep outputs on flip-flops at the cost of a gap between writes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !w_take && !s_axi_bvalid;
    end
  end

  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign widx = awaddr_q[ADDR_W-1:2];
  // write decode; capture registers answer OKAY but keep their value
  always_comb begin
    whit = 1'b0;
    unique case (widx)
      IDX_REF_WINDOW, IDX_EXPECTED, IDX_PLUS_LIM, IDX_MINUS_LIM: whit = 1'b1;
      IDX_SYS_CAPT, IDX_PLL_CAPT: whit = 1'b1;
      IDX_FAULT_STAT, IDX_FAULT_MASK: whit = 1'b1;
      default: whit = 1'b0;
    endcase
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= whit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers, byte-lane writes
  // byte lanes 0 and 1 carry the 16-bit registers; unmapped words change nothing
  // reference field only 14 bits wide
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q.ref_window <= RST_REF_WINDOW;
      cfg_q.expected <= RST_EXPECTED;
      cfg_q.plus_lim <= RST_PLUS_LIM;
      cfg_q.minus_lim <= RST_MINUS_LIM;
      mask_q <= RST_MASK;
    end else if (do_write) begin
      for (int b = 0; b < 2; b++) begin
        if (wstrb_q[b]) begin
          unique case (widx)
            IDX_REF_WINDOW: begin
              if (b == 0) begin
                cfg_q.ref_window[7:0] <= wdata_q[7:0];
              end else begin
                cfg_q.ref_window[13:8] <= wdata_q[13:8];
              end
            end
            IDX_EXPECTED: cfg_q.expected[b*8 +: 8] <= wdata_q[b*8 +: 8];
            IDX_PLUS_LIM: cfg_q.plus_lim[b*8 +: 8] <= wdata_q[b*8 +: 8];
            IDX_MINUS_LIM: cfg_q.minus_lim[b*8 +: 8] <= wdata_q[b*8 +: 8];
            IDX_FAULT_MASK: mask_q[b*8 +: 8] <= wdata_q[b*8 +: 8] & STAT_IMPL[b*8 +: 8];
            default: begin
            end
          endcase
        end
      end
    end
  end

  // status set and clear terms for this cycle
  always_comb begin
    stat_clr = 16'h0000;
    stat_set = 16'h0000;
    if (do_write && widx == IDX_FAULT_STAT) begin
      stat_clr[7:0] = wstrb_q[0] ? wdata_q[7:0] : 8'h00;
      stat_clr[15:8] = wstrb_q[1] ? wdata_q[15:8] : 8'h00;
    end
    stat_set[BIT_SYS_FREQ] = freq_loss_evt[0];
    stat_set[BIT_SYS_PPM] = out_of_win[0];
    stat_set[BIT_PLL_FREQ] = freq_loss_evt[1];
    stat_set[BIT_PLL_PPM] = out_of_win[1];
  end

  // sticky frequency and ppm loss flags
  // a new event in the clearing cycle wins over the clear, so no loss goes unseen
  // bits outside the four flags are held at zero and read as zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= ((stat_q & ~stat_clr) | stat_set) & STAT_IMPL;
    end
  end

  // interrupt level from unmasked flags
  // one cycle behind the flags, traded for an output straight from a flip-flop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // read decode
  // unmapped words read zero and answer SLVERR
  assign ridx = s_axi_araddr[ADDR_W-1:2];
  always_comb begin
    rval = 16'h0000;
    rhit = 1'b1;
    unique case (ridx)
      IDX_REF_WINDOW: rval = {2'b00, cfg_q.ref_window};
      IDX_EXPECTED: rval = cfg_q.expected;
      IDX_PLUS_LIM: rval = cfg_q.plus_lim;
      IDX_MINUS_LIM: rval = cfg_q.minus_lim;
      IDX_SYS_CAPT: rval = capt_q[0];
      IDX_PLL_CAPT: rval = capt_q[1];
      IDX_FAULT_STAT: rval = stat_q;
      IDX_FAULT_MASK: rval = mask_q;
      default: rhit = 1'b0;
    endcase
  end

  // read channel, data one cycle after the address is taken
  // the address is decoded as it is taken, so no address register is needed
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rval};
        s_axi_rresp <= rhit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/unused_placeholder_removed.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// File: verif/cpm_monitor_properties.sv
// checker for the clock ppm monitor register bus
// assumes binding to cpm_monitor, one clock domain
`timescale 1ns/100ps
`default_nettype none
module cpm_monitor_properties
  import cpm_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // handshake steps
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_r_lat;
    s_ar_take |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  // response two cycles after the pair is taken
  property p_b_lat;
    s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer off time");
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
  property p_aw_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("write taken while busy");
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
  property p_ref_rsvd;
    s_ar_take ##0 (s_axi_araddr == {IDX_REF_WINDOW, 2'b00}) |=> s_axi_rdata[15:14] == 2'b00;
  endproperty
  a_ref_rsvd: assert property (p_ref_rsvd) else $error("reserved bits set");
  property p_rdata_hi;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read half set");
endmodule
bind cpm_monitor cpm_monitor_properties u_props (.sys_clk, .arst_n, .s_axi_araddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// File: verif/cpm_monitor_tb.sv
// self-checking bench of the clock ppm monitor
// assumes ticks and loss events as one-cycle pulses on sys_clk
`timescale 1ns/100ps
`default_nettype none
module cpm_monitor_tb;
  import cpm_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, ref_tick = 1'b0;
  logic [1:0] mon_tick = 2'b00, loss = 2'b00, bresp, rresp, r;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] wdata = '0, rdata, v;
  logic [3:0] wstrb = 4'h0, wstrb_sel = 4'hf;
  int n_errors = 0, n_tests = 0, cyc = 0;
  cpm_monitor DUT (.sys_clk(sys_clk), .arst_n(arst_n), .ref_tick(ref_tick), .mon_tick(mon_tick),
    .freq_loss_evt(loss), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_q(irq));
  always #5 sys_clk = ~sys_clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // write one register; address and data offered together, each dropped when taken
  task wr(input logic [9:0] i, input logic [15:0] d);
    @(posedge sys_clk);
    awaddr <= {i, 2'b00};
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= wstrb_sel;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [9:0] i);
    @(posedge sys_clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // one window of four reference ticks, watched ticks spaced two cycles apart
  task win(input int ns, input int np);
    for (int k = 0; k < 80; k++) begin
      @(posedge sys_clk);
      mon_tick <= {k % 2 == 0 && k / 2 < np, k % 2 == 0 && k / 2 < ns};
      ref_tick <= (k % 20 == 19);
    end
    @(posedge sys_clk);
    mon_tick <= 2'b00;
    ref_tick <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task t_reset;
    logic [9:0] ix [8] = '{IDX_REF_WINDOW, IDX_EXPECTED, IDX_PLUS_LIM, IDX_MINUS_LIM, IDX_SYS_CAPT,
      IDX_PLL_CAPT, IDX_FAULT_STAT, IDX_FAULT_MASK};
    logic [15:0] e [8] = '{16'h30d3, 16'hf423, 16'h0044, 16'hf3df, 16'hf423, 16'hf423, 16'h0, 16'h0};
    for (int k = 0; k < 8; k++) begin
      rd(ix[k]);
      chk(v, {16'h0000, e[k]});
    end
    $display("reset values done");
  endtask
  task t_regs;
    wr(IDX_REF_WINDOW, 16'hffff);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(IDX_REF_WINDOW);
    chk(v, 32'h3fff);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    // only byte lane 0 enabled: upper field bits keep their value
    wstrb_sel = 4'h1;
    wr(IDX_REF_WINDOW, 16'h0000);
    wstrb_sel = 4'hf;
    rd(IDX_REF_WINDOW);
    chk(v, 32'h3f00);
    wr(IDX_SYS_CAPT, 16'h1234);
    rd(IDX_SYS_CAPT);
    chk(v, 32'hf423);
    wr(10'h100, 16'h5555);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(10'h100);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    // short window: 4 reference ticks, wrap after 20
    wr(IDX_REF_WINDOW, 16'h0003);
    wr(IDX_EXPECTED, 16'h0014);
    wr(IDX_PLUS_LIM, 16'h0002);
    wr(IDX_MINUS_LIM, 16'h0012);
    rd(IDX_EXPECTED);
    chk(v, 32'h0014);
    $display("register access done");
  endtask
  task t_cap;
    // 12500 ticks align the window whether or not a write reloads it
    repeat (12500) begin
      @(posedge sys_clk);
      ref_tick <= 1'b1;
      @(posedge sys_clk);
      ref_tick <= 1'b0;
    end
    win(18, 23);
    rd(IDX_FAULT_STAT);
    chk(v, 32'h0000);
    rd(IDX_SYS_CAPT);
    chk(v, 32'h0012);
    rd(IDX_PLL_CAPT);
    chk(v, 32'h0002);
    win(17, 24);
    rd(IDX_FAULT_STAT);
    chk(v, 32'h0220);
    rd(IDX_SYS_CAPT);
    chk(v, 32'h0011);
    rd(IDX_PLL_CAPT);
    chk(v, 32'h0003);
    wr(IDX_FAULT_STAT, 16'h0200);
    rd(IDX_FAULT_STAT);
    chk(v, 32'h0020);
    wr(IDX_FAULT_STAT, 16'h0020);
    $display("capture and window done");
  endtask
  task t_irq;
    @(posedge sys_clk);
    loss <= 2'b11;
    @(posedge sys_clk);
    loss <= 2'b00;
    rd(IDX_FAULT_STAT);
    chk(v, 32'h0440);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_FAULT_MASK, 16'h0400);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_FAULT_STAT, 16'h0400);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    rd(IDX_FAULT_STAT);
    chk(v, 32'h0040);
    wr(IDX_FAULT_MASK, 16'h0040);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    $display("interrupt done");
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, about 25000 cycles expected
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      test_done;
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset;
    t_regs;
    t_cap;
    t_irq;
    test_done;
  end
endmodule
`default_nettype wire
